/* rtl/ilgss_top.sv */
// ilgss_top: level detect, gain switch and input scaling for two ADC ports
// assumes: ADC pins are in another domain; AXI4-Lite master on i_sys_clk
//
// Functional notes
// - upper and lower thresholds per detector
// - above upper asserts the indicator
// - below lower starts dwell count
// - back above lower resets the count
// - count terminal drops the indicator
// - four independent detectors and indicators
// - each detector selects any input source
// - detection uses raw wideband samples
// - quiet scale bits 9:5, loud 4:0
// - scale switch delayed up to seven clocks
// - mantissa, exponent, qualifier sampled per port
// - exponent scaled before resampling filter
// - inverted shift is (7-exp+scale) mod 32
// - plain mode shifts right by exponent, twice the exponent with weight set
// - invert shifts up as exponent grows
// - offset shifts down, wraps modulo 32
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/100ps
`default_nettype none
module ilgss_top #(
   parameter int unsigned DWELL_W = ilgss_pkg::DWELL_W
) (
   input  wire logic                          i_sys_clk,       // 25 MHz clock
   input  wire logic                          i_nrst,          // async reset, low
   input  wire logic [ilgss_pkg::MANT_W-1:0]  i_port_a_mant,   // port a mantissa
   input  wire logic [ilgss_pkg::EXP_W-1:0]   i_port_a_exp,    // port a exponent_input
   input  wire logic                          i_port_a_qual,   // port a sample_qualifier
   input  wire logic [ilgss_pkg::MANT_W-1:0]  i_port_b_mant,   // port b mantissa
   input  wire logic [ilgss_pkg::EXP_W-1:0]   i_port_b_exp,    // port b exponent_input
   input  wire logic                          i_port_b_qual,   // port b sample_qualifier
   output logic                               o_port_a_indicator_first,  // detector 0
   output logic                               o_port_a_indicator_second, // detector 1
   output logic                               o_port_b_indicator_first,  // detector 2
   output logic                               o_port_b_indicator_second, // detector 3
   output logic [ilgss_pkg::OUT_W-1:0]        o_port_a_scaled, // port a to filter
   output logic [ilgss_pkg::OUT_W-1:0]        o_port_b_scaled, // port b to filter
   input  wire logic [ilgss_pkg::ADDR_W-1:0]  s_axi_awaddr,    // write address
   input  wire logic                          s_axi_awvalid,   // write address valid
   output logic                               s_axi_awready,   // write address ready
   input  wire logic [31:0]                   s_axi_wdata,     // write data
   input  wire logic [3:0]                    s_axi_wstrb,     // write strobes
   input  wire logic                          s_axi_wvalid,    // write data valid
   output logic                               s_axi_wready,    // write data ready
   output logic [1:0]                         s_axi_bresp,     // write response
   output logic                               s_axi_bvalid,    // write response valid
   input  wire logic                          s_axi_bready,    // write response ready
   input  wire logic [ilgss_pkg::ADDR_W-1:0]  s_axi_araddr,    // read address
   input  wire logic                          s_axi_arvalid,   // read address valid
   output logic                               s_axi_arready,   // read address ready
   output logic [31:0]                        s_axi_rdata,     // read data
   output logic [1:0]                         s_axi_rresp,     // read response
   output logic                               s_axi_rvalid,    // read data valid
   input  wire logic                          s_axi_rready     // read data ready
);
   localparam int unsigned MW = ilgss_pkg::MANT_W;
   localparam int unsigned ND = ilgss_pkg::NUM_DET;

   function automatic logic [MW-1:0] mag_of(input logic [MW-1:0] v);
      mag_of = v[MW-1] ? MW'(~v + MW'(1)) : v;
   endfunction

   function automatic logic [9:0] word_idx(input logic [ilgss_pkg::ADDR_W-1:0] a);
      word_idx = a[11:2];
   endfunction

   // two-stage synchronisers for the pin inputs
   logic [MW+3:0] sync_a1, sync_a2, sync_b1, sync_b2;

   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         sync_a1 <= '0;
         sync_a2 <= '0;
         sync_b1 <= '0;
         sync_b2 <= '0;
      end
      else
      begin
         sync_a1 <= {i_port_a_qual, i_port_a_exp, i_port_a_mant};
         sync_a2 <= sync_a1;
         sync_b1 <= {i_port_b_qual, i_port_b_exp, i_port_b_mant};
         sync_b2 <= sync_b1;
      end
   end

   // registers
   logic [9:0]         gain_scale;
   logic [31:0]        ctrl;
   logic [DWELL_W-1:0] dwell;
   logic [31:0]        thr [ND];

   // time-multiplexed phase per port toggles on each qualified sample
   logic phase_a, phase_b;
   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         phase_a <= 1'b0;
         phase_b <= 1'b0;
      end
      else
      begin
         if (sync_a2[MW+3])
            phase_a <= ~phase_a;
         if (sync_b2[MW+3])
            phase_b <= ~phase_b;
      end
   end

   // detectors look at raw mantissa magnitude
   logic [MW-1:0] mag_a, mag_b;
   assign mag_a = mag_of(sync_a2[MW-1:0]);
   assign mag_b = mag_of(sync_b2[MW-1:0]);

   logic [ND-1:0] det_active;
   logic [ND-1:0] det_counting;

   genvar g;
   generate
      for (g = 0; g < ND; g++)
      begin : gen_det
         logic [1:0]    src;
         logic          valid;
         logic [MW-1:0] mag;
         assign src = ctrl[ilgss_pkg::CTRL_SRC_LSB + 2*g +: 2];
         // source select, two or four inputs
         always_comb
         begin
            mag   = src[1] ? mag_b : mag_a;
            valid = src[1] ? sync_b2[MW+3] : sync_a2[MW+3];
            if (ctrl[ilgss_pkg::CTRL_TMUX])
               valid = valid && ((src[1] ? phase_b : phase_a) == src[0]);
         end
         ilgss_level_det #(
            .MAG_W   (MW),
            .DWELL_W (DWELL_W)
         ) u_det (
            .i_sys_clk   (i_sys_clk),
            .i_nrst      (i_nrst),
            .i_mag       (mag),
            .i_valid     (valid),
            .i_thr_upper (thr[g][MW-1:0]),
            .i_thr_lower (thr[g][ilgss_pkg::THR_LOW_LSB +: MW]),
            .i_dwell     (dwell),
            .o_active    (det_active[g]),
            .o_counting  (det_counting[g])
         );
      end
   endgenerate

   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_port_a_indicator_first  <= 1'b0;
         o_port_a_indicator_second <= 1'b0;
         o_port_b_indicator_first  <= 1'b0;
         o_port_b_indicator_second <= 1'b0;
      end
      else
      begin
         o_port_a_indicator_first  <= det_active[0];
         o_port_a_indicator_second <= det_active[1];
         o_port_b_indicator_first  <= det_active[2];
         o_port_b_indicator_second <= det_active[3];
      end
   end

   logic [7:0] hist_a, hist_b;
   logic [2:0] delay;
   logic       loud_a, loud_b;
   assign delay = ctrl[ilgss_pkg::CTRL_DELAY_LSB +: ilgss_pkg::DELAY_W];
   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         hist_a <= '0;
         hist_b <= '0;
      end
      else
      begin
         hist_a <= {hist_a[6:0], det_active[0]};
         hist_b <= {hist_b[6:0], det_active[2]};
      end
   end
   assign loud_a = hist_a[delay];
   assign loud_b = hist_b[delay];

   logic [4:0] scale_a, scale_b;
   assign scale_a = loud_a ? gain_scale[ilgss_pkg::LOUD_LSB +: 5] : gain_scale[ilgss_pkg::QUIET_LSB +: 5];
   assign scale_b = loud_b ? gain_scale[ilgss_pkg::LOUD_LSB +: 5] : gain_scale[ilgss_pkg::QUIET_LSB +: 5];

   // scale ahead of the resampling filter
   ilgss_scaler u_scale_a (
      .i_sys_clk (i_sys_clk),
      .i_nrst    (i_nrst),
      .i_mant    (sync_a2[MW-1:0]),
      .i_exp     (sync_a2[MW +: 3]),
      .i_scale   (scale_a),
      .i_invert  (ctrl[ilgss_pkg::CTRL_EXPONENT_INVERT]),
      .i_weight  (ctrl[ilgss_pkg::CTRL_WEIGHT]),
      .o_data    (o_port_a_scaled)
   );
   ilgss_scaler u_scale_b (
      .i_sys_clk (i_sys_clk),
      .i_nrst    (i_nrst),
      .i_mant    (sync_b2[MW-1:0]),
      .i_exp     (sync_b2[MW +: 3]),
      .i_scale   (scale_b),
      .i_invert  (ctrl[ilgss_pkg::CTRL_EXPONENT_INVERT]),
      .i_weight  (ctrl[ilgss_pkg::CTRL_WEIGHT]),
      .o_data    (o_port_b_scaled)
   );

   // AXI4-Lite write side: address and data taken in either order
   logic       aw_held, w_held;
   logic [9:0] aw_idx;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        do_write;
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_idx        <= '0;
         w_data        <= '0;
         w_strb        <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= ilgss_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_idx  <= word_idx(s_axi_awaddr);
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_idx == 10'(ilgss_pkg::IDX_GAIN_SCALE) || aw_idx == 10'(ilgss_pkg::IDX_CTRL) ||
                             aw_idx == 10'(ilgss_pkg::IDX_DWELL) ||
                             (aw_idx >= 10'(ilgss_pkg::IDX_THR_BASE) && aw_idx < 10'(ilgss_pkg::IDX_THR_BASE + ND)))
                            ? ilgss_pkg::RESP_OKAY : ilgss_pkg::RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      for (int i = 0; i < 4; i++)
         merge[8*i +: 8] = st[i] ? nw[8*i +: 8] : old[8*i +: 8];
   endfunction

   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         gain_scale <= ilgss_pkg::GAIN_RESET;
         ctrl       <= '0;
         dwell      <= '0;
         for (int i = 0; i < ND; i++)
            thr[i] <= '0;
      end
      else if (do_write)
      begin
         if (aw_idx == 10'(ilgss_pkg::IDX_GAIN_SCALE))
            gain_scale <= 10'(merge({22'h0, gain_scale}, w_data, w_strb));
         if (aw_idx == 10'(ilgss_pkg::IDX_CTRL))
            ctrl <= merge(ctrl, w_data, w_strb);
         if (aw_idx == 10'(ilgss_pkg::IDX_DWELL))
            dwell <= DWELL_W'(merge(32'(dwell), w_data, w_strb));
         for (int i = 0; i < ND; i++)
            if (aw_idx == 10'(ilgss_pkg::IDX_THR_BASE + i))
               thr[i] <= merge(thr[i], w_data, w_strb);
      end
   end

   // AXI4-Lite read side, one cycle after address accept
   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= ilgss_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= ilgss_pkg::RESP_OKAY;
            s_axi_rdata  <= '0;
            case (word_idx(s_axi_araddr))
               10'(ilgss_pkg::IDX_GAIN_SCALE): s_axi_rdata <= {22'h0, gain_scale};
               10'(ilgss_pkg::IDX_CTRL):       s_axi_rdata <= ctrl;
               10'(ilgss_pkg::IDX_DWELL):      s_axi_rdata <= 32'(dwell);
               10'(ilgss_pkg::IDX_STATUS):     s_axi_rdata <= {24'h0, det_counting, det_active};
               10'(ilgss_pkg::IDX_THR_BASE):   s_axi_rdata <= thr[0];
               10'(ilgss_pkg::IDX_THR_BASE+1): s_axi_rdata <= thr[1];
               10'(ilgss_pkg::IDX_THR_BASE+2): s_axi_rdata <= thr[2];
               10'(ilgss_pkg::IDX_THR_BASE+3): s_axi_rdata <= thr[3];
               default:                        s_axi_rresp <= ilgss_pkg::RESP_SLVERR;
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // loud field used while indicator delayed active
   AST_LOUD_SEL: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      loud_a |-> scale_a == gain_scale[4:0])
      else $error("loud scale not selected");
   // zero delay follows detector one cycle later
   AST_DELAY0: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (delay == 3'h0) |-> loud_a == $past(det_active[0]))
      else $error("delay alignment wrong");
   // indicator follows detector one cycle later
   AST_IND_PIN: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      ##1 o_port_b_indicator_second == $past(det_active[3]))
      else $error("indicator pin not registered");
endmodule
`default_nettype wire

/* rtl/ilgss_pkg.sv */
// ilgss_pkg: register map, field layout and constants for the input level gain switch scaler
// assumes: a 32-bit AXI4-Lite register bus and one sample clock
package ilgss_pkg;
   localparam int unsigned ADDR_W        = 12;
   // the scale register offset is not a multiple of four, so offsets are indices
   localparam int unsigned IDX_GAIN_SCALE = 'h92;
   localparam int unsigned IDX_CTRL       = 'h90;
   localparam int unsigned IDX_DWELL      = 'h91;
   localparam int unsigned IDX_STATUS     = 'h93;
   localparam int unsigned IDX_THR_BASE   = 'hA0;
   localparam int unsigned NUM_DET        = 4;
   localparam int unsigned MANT_W         = 14;
   localparam int unsigned EXP_W          = 3;
   localparam int unsigned SCALE_W        = 5;
   localparam int unsigned OUT_W          = 24;
   localparam int unsigned DWELL_W        = 16;
   localparam int unsigned DELAY_W        = 3;
   // scale register fields
   localparam int unsigned QUIET_LSB      = 5;
   localparam int unsigned LOUD_LSB       = 0;
   // control register fields
   localparam int unsigned CTRL_EXPONENT_INVERT    = 0;
   localparam int unsigned CTRL_WEIGHT    = 1;
   localparam int unsigned CTRL_DELAY_LSB = 4;
   localparam int unsigned CTRL_PORT      = 8;
   localparam int unsigned CTRL_SRC_LSB   = 16;
   localparam int unsigned CTRL_TMUX      = 24;
   localparam int unsigned THR_LOW_LSB    = 16;
   localparam logic [9:0]  GAIN_RESET     = 10'h000;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   localparam logic [4:0]  EXP_BIAS       = 5'h07;
endpackage

/* rtl/ilgss_level_det.sv */
// ilgss_level_det: one threshold detector with dwell hysteresis
// assumes: magnitudes come from the same clock domain
`timescale 1ns/100ps
`default_nettype none
module ilgss_level_det #(
   parameter int unsigned MAG_W   = 14,
   parameter int unsigned DWELL_W = 16
) (
   input  wire logic               i_sys_clk,    // sample clock
   input  wire logic               i_nrst,       // async reset, low
   input  wire logic [MAG_W-1:0]   i_mag,        // sample magnitude
   input  wire logic               i_valid,      // sample qualifier
   input  wire logic [MAG_W-1:0]   i_thr_upper,  // upper threshold
   input  wire logic [MAG_W-1:0]   i_thr_lower,  // lower threshold
   input  wire logic [DWELL_W-1:0] i_dwell,      // dwell count
   output logic                    o_active,     // level indicator
   output logic                    o_counting    // dwell running
);
   logic [DWELL_W-1:0] count;
   logic               above_upper;
   logic               below_lower;

   assign above_upper = i_valid && (i_mag > i_thr_upper);
   assign below_lower = i_mag < i_thr_lower;

   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_active   <= 1'b0;
         o_counting <= 1'b0;
         count      <= '0;
      end
      else if (above_upper)
      begin
         o_active   <= 1'b1;
         o_counting <= 1'b0;
      end
      else if (o_active && i_valid)
      begin
         if (!below_lower)
         begin
            o_counting <= 1'b0;
         end
         else if (!o_counting)
         begin
            o_counting <= 1'b1;
            count      <= i_dwell;
            if (i_dwell == '0)
            begin
               o_active   <= 1'b0;
               o_counting <= 1'b0;
            end
         end
         else if (count <= DWELL_W'(1))
         begin
            o_active   <= 1'b0;
            o_counting <= 1'b0;
            count      <= '0;
         end
         else
         begin
            count <= count - DWELL_W'(1);
         end
      end
   end

   AST_ASSERT_ON_UPPER: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      above_upper |=> o_active)
      else $error("indicator not set after upper crossing");
   AST_RESTART: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (o_active && i_valid && !below_lower && !above_upper) |=> !o_counting && o_active)
      else $error("dwell not restarted");
   // release only from counting or zero dwell
   AST_RELEASE: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      $fell(o_active) |-> $past(below_lower))
      else $error("indicator dropped without low level");
endmodule
`default_nettype wire

/* rtl/ilgss_scaler.sv */
// ilgss_scaler: exponent based shift of one mantissa
// assumes: scale already selected by the caller
`timescale 1ns/100ps
`default_nettype none
module ilgss_scaler (
   input  wire logic                          i_sys_clk,  // sample clock
   input  wire logic                          i_nrst,     // async reset, low
   input  wire logic [ilgss_pkg::MANT_W-1:0]  i_mant,     // mantissa
   input  wire logic [ilgss_pkg::EXP_W-1:0]   i_exp,      // exponent
   input  wire logic [ilgss_pkg::SCALE_W-1:0] i_scale,    // selected scale
   input  wire logic                          i_invert,   // exponent invert
   input  wire logic                          i_weight,   // exponent weight
   output logic [ilgss_pkg::OUT_W-1:0]        o_data      // scaled sample
);
   logic [ilgss_pkg::SCALE_W-1:0] shift;
   logic [ilgss_pkg::OUT_W-1:0]   wide;

   always_comb
   begin
      // inverted: 7 - exp + scale, mod 32
      if (i_invert)
         shift = ilgss_pkg::EXP_BIAS - {2'h0, i_exp} + i_scale;
      // plain: right shift grows with exp
      else
         shift = {2'h0, i_exp} + (i_weight ? {2'h0, i_exp} : 5'h00) + i_scale;
      wide = {i_mant, {(ilgss_pkg::OUT_W-ilgss_pkg::MANT_W){1'b0}}};
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         o_data <= '0;
      else
         o_data <= $signed(wide) >>> shift;
   end

   AST_INVERT_DIR: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (i_invert && i_exp == 3'h7 && i_scale == 5'h00) |-> shift == 5'h00)
      else $error("invert direction wrong");
   AST_WRAP: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (i_invert && i_exp == 3'h5 && i_scale == 5'h1E) |-> shift == 5'h00)
      else $error("offset wrap wrong");
endmodule
`default_nettype wire

/* testbench/ilgss_adc_model.sv */
// ilgss_adc_model: behavioural two-port converter in front of the block
// assumes: the bench requests codes; the pins move on the rising edge
`timescale 1ns/100ps
`default_nettype none
module ilgss_adc_model (
   input  wire logic        i_sys_clk, // sample clock
   input  wire logic [16:0] i_req_a,   // requested exponent and mantissa, port a
   input  wire logic [16:0] i_req_b,   // requested exponent and mantissa, port b
   output logic      [13:0] o_mant_a,  // port a mantissa
   output logic      [2:0]  o_exp_a,   // port a exponent
   output logic      [13:0] o_mant_b,  // port b mantissa
   output logic      [2:0]  o_exp_b,   // port b exponent
   output logic             o_qual     // qualifier of both ports
);
   logic [16:0] word_a = 17'h00000;
   logic [16:0] word_b = 17'h00000;
   always @(posedge i_sys_clk)
   begin
      word_a <= i_req_a;
      word_b <= i_req_b;
   end
   assign {o_exp_a, o_mant_a} = word_a;
   assign {o_exp_b, o_mant_b} = word_b;
   assign o_qual = 1'b1;
endmodule
`default_nettype wire

/* testbench/test_ilgss_top.sv */
// test_ilgss_top: self-checking bench for level detect and input scaling
// assumes: registers on AXI4-Lite, byte address is four times the index
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; $display("wrong value at %0t: %0h vs %0h", $time, (g), (e)); end end
module test_ilgss_top;
   logic        i_sys_clk = 1'b0;
   logic        i_nrst = 1'b0;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, rd;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid, qual;
   logic [1:0]  bresp, rresp, rr;
   logic [16:0] req_a = '0, req_b = '0;
   logic [13:0] mant_a, mant_b;
   logic [2:0]  exp_a, exp_b;
   logic [3:0]  ind;
   logic [23:0] sc_a, sc_b;
   logic [9:0]  c;
   logic [4:0]  q;
   logic [9:0]  cs [6] = '{10'h000, 10'h005, 10'h200, 10'h207, 10'h2F5, 10'h10B};
   int          err_count = 0, check_count = 0, i, k;
   always #20 i_sys_clk = ~i_sys_clk;
   ilgss_adc_model i_ilgss_adc_model (.i_sys_clk(i_sys_clk), .i_req_a(req_a), .i_req_b(req_b), .o_mant_a(mant_a),
      .o_exp_a(exp_a), .o_mant_b(mant_b), .o_exp_b(exp_b), .o_qual(qual));
   ilgss_top i_ilgss_top (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_port_a_mant(mant_a), .i_port_a_exp(exp_a),
      .i_port_a_qual(qual), .i_port_b_mant(mant_b), .i_port_b_exp(exp_b), .i_port_b_qual(qual),
      .o_port_a_indicator_first(ind[0]), .o_port_a_indicator_second(ind[1]), .o_port_b_indicator_first(ind[2]),
      .o_port_b_indicator_second(ind[3]), .o_port_a_scaled(sc_a), .o_port_b_scaled(sc_b),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   task automatic print_verdict();
      $display("checks %0d, errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 50 && !(bvalid && bready); n++)
      begin
         @(posedge i_sys_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      r = bresp;
      bready <= 1'b0;
      @(posedge i_sys_clk);
      if (n == 50) err_count++;
      if (n == 50) print_verdict();
   endtask
   task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 50 && !(rvalid && rready); n++)
      begin
         @(posedge i_sys_clk);
         if (arready) arvalid <= 1'b0;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge i_sys_clk);
      if (n == 50) err_count++;
      if (n == 50) print_verdict();
   endtask
   task automatic lvl(input logic [16:0] v, input int n);
      req_a <= v;
      repeat (n) @(posedge i_sys_clk);
   endtask
   function automatic logic [23:0] exp_sc(logic [13:0] m, logic [2:0] e, logic [4:0] s, logic inv, logic wt);
      logic [4:0] sh;
      sh = inv ? ilgss_pkg::EXP_BIAS - {2'h0, e} + s : {2'h0, e} + s + (wt ? {2'h0, e} : 5'h00);
      return $signed({m, 10'h000}) >>> sh;
   endfunction
   initial
   begin
      void'($urandom(79191));
      repeat (2) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      @(posedge i_sys_clk);
      axr(12'h248, rd, rr);
      `CHK(rd[9:0], ilgss_pkg::GAIN_RESET)
      axw(12'h100, 32'h0, rr);
      `CHK(rr, ilgss_pkg::RESP_SLVERR)
      axr(12'h100, rd, rr);
      `CHK({rr, rd}, {ilgss_pkg::RESP_SLVERR, 32'h0})
      for (i = 0; i < 4; i++) axw(12'h280 + 12'(4 * i), 32'h0000_3FFF, rr);
      // corner shift cases first, fixed-point setting in entry zero
      for (i = 0; i < 16; i++)
      begin
         c = (i < 6) ? cs[i] : 10'($urandom);
         q = 5'($urandom);
         axw(12'h240, {8'h00, 8'h28, 14'h0, c[8], c[9]}, rr);
         axw(12'h248, {22'h0, c[7:3], q}, rr);
         axr(12'h248, rd, rr);
         `CHK(rd, {22'h0, c[7:3], q})
         for (k = 0; k < 3; k++)
         begin
            req_a <= {(i < 6) ? c[2:0] : 3'($urandom), 14'($urandom)};
            req_b <= {(i < 6) ? c[2:0] : 3'($urandom), 14'($urandom)};
            repeat (8) @(posedge i_sys_clk);
            `CHK({sc_a, sc_b}, {exp_sc(req_a[13:0], req_a[16:14], c[7:3], c[9], c[8]), exp_sc(req_b[13:0], req_b[16:14], c[7:3], c[9], c[8])})
         end
      end
      // park both ports at zero so no detector trips while thresholds change
      req_a <= '0;
      req_b <= '0;
      for (i = 0; i < 4; i++) axw(12'h280 + 12'(4 * i), 32'h0400_1000, rr);
      axw(12'h244, 32'h0000_0006, rr);
      axw(12'h240, 32'h0028_0030, rr);
      axw(12'h248, 32'h0000_0061, rr);
      req_b <= 17'h00100;
      lvl(17'h0A800, 9);
      `CHK(sc_a, exp_sc(14'h2800, 3'h2, 5'h03, 1'b0, 1'b0))
      lvl(17'h0A800, 3);
      `CHK(ind, 4'b1001)
      `CHK({sc_a, sc_b}, {exp_sc(14'h2800, 3'h2, 5'h01, 1'b0, 1'b0), exp_sc(14'h0100, 3'h0, 5'h03, 1'b0, 1'b0)})
      axr(12'h24C, rd, rr);
      `CHK(rd[3:0], 4'b1001)
      lvl(17'h00100, 6);
      lvl(17'h00800, 3);
      lvl(17'h00100, 5);
      `CHK(ind, 4'b1001)
      lvl(17'h00100, 12);
      `CHK(ind, 4'b0000)
      `CHK(sc_a, exp_sc(14'h0100, 3'h0, 5'h03, 1'b0, 1'b0))
      print_verdict();
   end
endmodule
`default_nettype wire
